// ### rtl/lmcc_top.sv
// Local memory cycle control: strobes, decodes and channel fault capture.
`timescale 1ns/1ps
`include "lmcc_map.svh"
module lmcc_top (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic cfg_reset,
   input wire logic [3:0] byte_lane_sel_n,
   input wire logic [31:0] local_addr,
   input wire logic [1:0] status_n,
   input wire logic cpu_cycle,
   input wire logic dma_cycle,
   input wire logic refresh_cycle,
   input wire logic master_cycle,
   input wire logic cpu_mem_io,
   input wire logic cpu_start_n,
   input wire logic membus_cmd_n,
   input wire logic addr_decode_latch_n,
   input wire logic upper_addr_zero_i,
   output logic upper_addr_zero_o,
   output logic upper_addr_zero_oe,
   output logic local_dram_claim_n,
   output logic xbus_addr_bit_sixteen_o,
   output logic xbus_addr_bit_sixteen_oe,
   output logic xbus_data_en_n,
   input wire logic [7:0] dram_mux_addr_i,
   output logic [7:0] dram_mux_addr_o,
   output logic [7:0] dram_mux_addr_oe,
   input wire logic reg_access,
   input wire logic reg_write,
   input wire logic [7:0] dram_row_col_addr,
   input wire logic channel_fault_n,
   input wire logic data_cmd,
   input wire logic arb_phase,
   input wire logic [3:0] arb_level,
   output logic [31:0] fault_addr,
   output logic [1:0] fault_status,
   output logic fault_data_cmd,
   output logic fault_arb_phase,
   output logic [3:0] fault_arb_level,
   output logic fault_valid,
   output logic rom_sel_n,
   output logic rom_full_range_en,
   output logic [3:0] row_strobe_n,
   output logic [15:0] col_strobe_n
);
   // ****************************************
   // Input synchronisation
   // ****************************************
   logic [3:0] lane_n_s;
   logic [31:0] addr_s;
   logic [1:0] stat_s;
   logic [4:0] cyc_s;
   logic cmd_n_s, adl_n_s, uaz_s, flt_n_s, dc_s, arbp_s, start_n_s, acc_s, wr_s;
   logic [3:0] arbl_s;
   logic [7:0] mad_s, rcad_s;
   logic rst_cfg_s;
   lmcc_sync #(.WIDTH(4), .INIT(4'hF)) u_lane (.clk(clk), .rst_n(rst_n), .d(byte_lane_sel_n), .q(lane_n_s));
   lmcc_sync #(.WIDTH(32)) u_addr (.clk(clk), .rst_n(rst_n), .d(local_addr), .q(addr_s));
   lmcc_sync #(.WIDTH(2), .INIT(2'h3)) u_stat (.clk(clk), .rst_n(rst_n), .d(status_n), .q(stat_s));
   lmcc_sync #(.WIDTH(5)) u_cyc (.clk(clk), .rst_n(rst_n),
      .d({cpu_cycle, dma_cycle, refresh_cycle, master_cycle, cpu_mem_io}), .q(cyc_s));
   lmcc_sync #(.WIDTH(9), .INIT(9'h1FF)) u_ctl (.clk(clk), .rst_n(rst_n),
      .d({membus_cmd_n, addr_decode_latch_n, upper_addr_zero_i, channel_fault_n, data_cmd, arb_phase,
          cpu_start_n, reg_access, reg_write}),
      .q({cmd_n_s, adl_n_s, uaz_s, flt_n_s, dc_s, arbp_s, start_n_s, acc_s, wr_s}));
   lmcc_sync #(.WIDTH(4)) u_arbl (.clk(clk), .rst_n(rst_n), .d(arb_level), .q(arbl_s));
   lmcc_sync #(.WIDTH(16)) u_mad (.clk(clk), .rst_n(rst_n), .d({dram_mux_addr_i, dram_row_col_addr}),
      .q({mad_s, rcad_s}));
   lmcc_sync #(.WIDTH(1), .INIT(1'b1)) u_rcfg (.clk(clk), .rst_n(rst_n), .d(cfg_reset), .q(rst_cfg_s));

   // ****************************************
   // Cycle ownership
   // ****************************************
   lmcc_pkg::lmcc_owner_t owner;
   logic foreign;
   logic cpu_is, dma_is, rfsh_is, mst_is, memio_s;
   assign {cpu_is, dma_is, rfsh_is, mst_is, memio_s} = cyc_s;
   always_comb begin
      if (rfsh_is) begin
         owner = lmcc_pkg::LMCC_OWN_RFSH;
      end else if (mst_is) begin
         owner = lmcc_pkg::LMCC_OWN_MASTER;
      end else if (dma_is) begin
         owner = lmcc_pkg::LMCC_OWN_DMA;
      end else begin
         owner = lmcc_pkg::LMCC_OWN_CPU;
      end
   end
   assign foreign = (owner != lmcc_pkg::LMCC_OWN_CPU);

   // ****************************************
   // Decoding helpers
   // ****************************************
   // High when the eight upper address bits are all zero.
   function automatic logic upper_zero(input logic [31:0] addr);
      return addr[31:`LMCC_UPPER_LSB] == 8'h00;
   endfunction : upper_zero

   // ****************************************
   // Address and status latch
   // ****************************************
   logic adl_prev_ff, cmd_prev_ff, flt_prev_ff;
   logic [31:0] cyc_addr_ff;
   logic [1:0] cyc_stat_ff;
   logic uaz_lat_ff;
   logic adl_fall;
   logic uaz_cur;
   assign adl_fall = foreign && adl_prev_ff && !adl_n_s;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         adl_prev_ff <= 1'b1;
         cmd_prev_ff <= 1'b1;
         flt_prev_ff <= 1'b1;
      end else begin
         adl_prev_ff <= adl_n_s;
         cmd_prev_ff <= cmd_n_s;
         flt_prev_ff <= flt_n_s;
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cyc_addr_ff <= 32'h0000_0000;
         cyc_stat_ff <= 2'h3;
         uaz_lat_ff <= 1'b1;
      end else if (adl_fall) begin
         cyc_addr_ff <= addr_s;
         cyc_stat_ff <= stat_s;
         uaz_lat_ff <= uaz_s;
      end else if (!foreign && !start_n_s) begin
         cyc_addr_ff <= addr_s;
         cyc_stat_ff <= stat_s;
         uaz_lat_ff <= upper_zero(addr_s);
      end
   end
   // A foreign cycle decodes its address on the latch edge itself, so no stale bank is strobed.
   assign uaz_cur = adl_fall ? uaz_s : uaz_lat_ff;

   // ****************************************
   // Upper address zero and X bus
   // ****************************************
   assign upper_addr_zero_oe = !foreign;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         upper_addr_zero_o <= 1'b1;
      end else begin
         upper_addr_zero_o <= upper_zero(addr_s);
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         xbus_addr_bit_sixteen_o <= 1'b0;
         xbus_addr_bit_sixteen_oe <= 1'b0;
      end else begin
         xbus_addr_bit_sixteen_o <= addr_s[16];
         xbus_addr_bit_sixteen_oe <= cpu_is && !memio_s;
      end
   end

   // ****************************************
   // Register access over the mux lines
   // ****************************************
   logic rom_cfg_reg_ff;
   logic reg_rd;
   assign reg_rd = acc_s && !wr_s && !cmd_n_s;
   assign xbus_data_en_n = !(acc_s && !cmd_n_s);
   assign dram_mux_addr_oe = (reg_rd || !acc_s) ? 8'hFF : 8'h00;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dram_mux_addr_o <= 8'h00;
      end else if (acc_s) begin
         dram_mux_addr_o <= {7'h00, rom_cfg_reg_ff};
      end else begin
         dram_mux_addr_o <= rcad_s;
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rom_cfg_reg_ff <= `LMCC_ROM_CFG_RESET;
      end else if (rst_cfg_s) begin
         rom_cfg_reg_ff <= `LMCC_ROM_CFG_RESET;
      end else if (acc_s && wr_s && cmd_prev_ff && !cmd_n_s) begin
         rom_cfg_reg_ff <= mad_s[0];
      end
   end
   assign rom_full_range_en = rom_cfg_reg_ff;

   // ****************************************
   // ROM select and DRAM claim
   // ****************************************
   logic [31:0] cur_addr;
   logic [19:0] low_addr;
   logic rom_hit, dram_hit;
   logic addr_ok;
   assign addr_ok = (!foreign || !adl_n_s) && !(mst_is && !uaz_cur);
   assign cur_addr = (foreign && !adl_fall) ? cyc_addr_ff : addr_s;
   assign low_addr = cur_addr[19:0];
   always_comb begin
      rom_hit = 1'b0;
      if (cur_addr[31:20] == 12'h000 && low_addr >= `LMCC_ROM_BASE) begin
         if (rom_cfg_reg_ff) begin
            rom_hit = (low_addr <= `LMCC_ROM_TOP_FULL);
         end else begin
            rom_hit = (low_addr <= `LMCC_ROM_TOP_PART);
         end
      end
   end
   assign dram_hit = upper_zero(cur_addr) && !rom_hit && (memio_s || foreign) && addr_ok;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rom_sel_n <= 1'b1;
         local_dram_claim_n <= 1'b1;
      end else begin
         rom_sel_n <= !(rom_hit && (memio_s || foreign) && addr_ok && !rfsh_is);
         if (mst_is && !uaz_cur) begin
            local_dram_claim_n <= 1'b1;
         end else begin
            local_dram_claim_n <= !(dram_hit && !rfsh_is);
         end
      end
   end

   // ****************************************
   // Row and column strobe sequencer
   // ****************************************
   lmcc_pkg::lmcc_state_t state_ff, nxt_state;
   logic [1:0] bank;
   logic active;
   assign bank = cur_addr[`LMCC_BANK_LSB+1:`LMCC_BANK_LSB];
   assign active = (dram_hit && !cmd_n_s) || (rfsh_is && !cmd_n_s);
   always_comb begin
      case (state_ff)
         lmcc_pkg::LMCC_IDLE: nxt_state = active ? lmcc_pkg::LMCC_ROW : lmcc_pkg::LMCC_IDLE;
         lmcc_pkg::LMCC_ROW: nxt_state = active ? lmcc_pkg::LMCC_COL : lmcc_pkg::LMCC_IDLE;
         lmcc_pkg::LMCC_COL: nxt_state = active ? lmcc_pkg::LMCC_COL : lmcc_pkg::LMCC_IDLE;
         default: nxt_state = lmcc_pkg::LMCC_IDLE;
      endcase
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= lmcc_pkg::LMCC_IDLE;
      end else if (rst_cfg_s) begin
         state_ff <= lmcc_pkg::LMCC_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         row_strobe_n <= `LMCC_RAS_IDLE;
         col_strobe_n <= `LMCC_CAS_IDLE;
      end else if (rst_cfg_s || nxt_state == lmcc_pkg::LMCC_IDLE) begin
         row_strobe_n <= `LMCC_RAS_IDLE;
         col_strobe_n <= `LMCC_CAS_IDLE;
      end else if (rfsh_is) begin
         row_strobe_n <= 4'h0;
         col_strobe_n <= `LMCC_CAS_IDLE;
      end else begin
         row_strobe_n <= ~(4'h1 << bank);
         if (nxt_state == lmcc_pkg::LMCC_COL) begin
            col_strobe_n <= ~({12'h000, ~lane_n_s} << {bank, 2'b00});
         end
      end
   end

   // ****************************************
   // Channel fault capture
   // ****************************************
   lmcc_fault_latch u_fault (
      .clk(clk),
      .rst_n(rst_n),
      .fault_fall(flt_prev_ff && !flt_n_s),
      .chan_addr(cyc_addr_ff),
      .chan_status(cyc_stat_ff),
      .data_cmd(dc_s),
      .arb_phase(arbp_s),
      .arb_level(arbl_s),
      .fault_addr(fault_addr),
      .fault_status(fault_status),
      .fault_data_cmd(fault_data_cmd),
      .fault_arb_phase(fault_arb_phase),
      .fault_arb_level(fault_arb_level),
      .fault_valid(fault_valid)
   );
endmodule : lmcc_top

// ### rtl/lmcc_map.svh
// Constants of the local memory cycle control block.
`ifndef LMCC_MAP_SVH
`define LMCC_MAP_SVH
`define LMCC_ROM_BASE 20'hC_0000
`define LMCC_ROM_TOP_FULL 20'hF_FFFF
`define LMCC_ROM_TOP_PART 20'hD_FFFF
`define LMCC_ROM_CFG_RESET 1'b1
`define LMCC_UPPER_LSB 24
`define LMCC_BANK_LSB 20
`define LMCC_RAS_IDLE 4'hF
`define LMCC_CAS_IDLE 16'hFFFF
`endif

// ### rtl/lmcc_pkg.sv
// Types of the local memory cycle control block.
package lmcc_pkg;
   typedef enum logic [1:0] {
      LMCC_IDLE = 2'b00,
      LMCC_ROW = 2'b01,
      LMCC_COL = 2'b10
   } lmcc_state_t;
   typedef enum logic [1:0] {
      LMCC_OWN_CPU = 2'b00,
      LMCC_OWN_DMA = 2'b01,
      LMCC_OWN_RFSH = 2'b10,
      LMCC_OWN_MASTER = 2'b11
   } lmcc_owner_t;
endpackage : lmcc_pkg

// ### rtl/lmcc_sync.sv
// Two-stage synchroniser for pin inputs.
`timescale 1ns/1ps
module lmcc_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] INIT = '0
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta_ff;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_ff <= INIT;
         q <= INIT;
      end else begin
         meta_ff <= d;
         q <= meta_ff;
      end
   end
endmodule : lmcc_sync

// ### rtl/lmcc_fault_latch.sv
// Capture of channel address and status on a channel fault.
`timescale 1ns/1ps
module lmcc_fault_latch (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic fault_fall,
   input wire logic [31:0] chan_addr,
   input wire logic [1:0] chan_status,
   input wire logic data_cmd,
   input wire logic arb_phase,
   input wire logic [3:0] arb_level,
   output logic [31:0] fault_addr,
   output logic [1:0] fault_status,
   output logic fault_data_cmd,
   output logic fault_arb_phase,
   output logic [3:0] fault_arb_level,
   output logic fault_valid
);
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         fault_addr <= 32'h0000_0000;
         fault_status <= 2'h0;
         fault_data_cmd <= 1'b0;
         fault_arb_phase <= 1'b0;
         fault_arb_level <= 4'h0;
         fault_valid <= 1'b0;
      end else if (fault_fall) begin
         fault_addr <= chan_addr;
         fault_status <= chan_status;
         fault_data_cmd <= data_cmd;
         fault_arb_phase <= arb_phase;
         fault_arb_level <= arb_level;
         fault_valid <= 1'b1;
      end
   end
endmodule : lmcc_fault_latch

// ### tb/lmcc_top_monitor.sv
// Port checker of the local memory cycle control block, bound to its top.
`timescale 1ns/1ps
`include "lmcc_map.svh"
module lmcc_top_monitor (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic cfg_reset,
   input wire logic [3:0] byte_lane_sel_n,
   input wire logic [31:0] local_addr,
   input wire logic cpu_cycle,
   input wire logic dma_cycle,
   input wire logic refresh_cycle,
   input wire logic master_cycle,
   input wire logic cpu_mem_io,
   input wire logic cpu_start_n,
   input wire logic membus_cmd_n,
   input wire logic addr_decode_latch_n,
   input wire logic upper_addr_zero_i,
   input wire logic upper_addr_zero_o,
   input wire logic upper_addr_zero_oe,
   input wire logic local_dram_claim_n,
   input wire logic channel_fault_n,
   input wire logic [3:0] arb_level,
   input wire logic [3:0] fault_arb_level,
   input wire logic fault_valid,
   input wire logic rom_sel_n,
   input wire logic rom_full_range_en,
   input wire logic [3:0] row_strobe_n,
   input wire logic [15:0] col_strobe_n
);
   // ********************************
   // Checks
   // ********************************
   logic cpu_only;
   logic [3:0] col_idle;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   assign cpu_only = cpu_cycle && !dma_cycle && !refresh_cycle && !master_cycle && !cpu_start_n && !membus_cmd_n;
   assign col_idle = {&col_strobe_n[15:12], &col_strobe_n[11:8], &col_strobe_n[7:4], &col_strobe_n[3:0]};
   AST_CFG_IDLE: assert property (cfg_reset[*4] |-> row_strobe_n == `LMCC_RAS_IDLE && col_strobe_n == `LMCC_CAS_IDLE)
      else $error("strobes active under config reset");
   AST_UZ_FREE: assert property ((dma_cycle || refresh_cycle || master_cycle)[*3] |-> !upper_addr_zero_oe)
      else $error("upper zero driven on foreign cycle");
   AST_UZ_DRIVE: assert property ((cpu_only && $stable(local_addr))[*4]
      |-> upper_addr_zero_oe && upper_addr_zero_o == (local_addr[31:24] == 8'h00)) else $error("upper zero wrong");
   AST_NO_CLAIM: assert property ($fell(addr_decode_latch_n) && master_cycle && !upper_addr_zero_i
      ##1 (master_cycle && !upper_addr_zero_i)[*7] |-> local_dram_claim_n) else $error("claim with upper zero low");
   AST_ROM: assert property ((cpu_only && cpu_mem_io && local_addr[31:20] == 12'h000 && $stable(local_addr))[*4]
      |-> rom_sel_n == !(local_addr[19:0] >= `LMCC_ROM_BASE
      && local_addr[19:0] <= (rom_full_range_en ? `LMCC_ROM_TOP_FULL : `LMCC_ROM_TOP_PART))) else $error("rom select wrong");
   AST_BANK: assert property (&(col_idle | ~row_strobe_n))
      else $error("column strobe outside the selected bank");
   AST_LANES: assert property ((cpu_only && cpu_mem_io && !cfg_reset && $stable({local_addr, byte_lane_sel_n}))[*6]
      |-> local_dram_claim_n || col_strobe_n == ~({4'h0, 4'h0, 4'h0, ~byte_lane_sel_n} << {local_addr[21:20], 2'b00}))
      else $error("column strobes do not match lanes");
   AST_FAULT: assert property ($fell(channel_fault_n) ##1 (!channel_fault_n && $stable(arb_level))[*4]
      |-> fault_valid && fault_arb_level == arb_level) else $error("arbitration level not captured");
endmodule : lmcc_top_monitor
bind lmcc_top lmcc_top_monitor u_mon (.clk, .rst_n, .cfg_reset, .byte_lane_sel_n, .local_addr, .cpu_cycle, .dma_cycle,
   .refresh_cycle, .master_cycle, .cpu_mem_io, .cpu_start_n, .membus_cmd_n, .addr_decode_latch_n, .upper_addr_zero_i,
   .upper_addr_zero_o, .upper_addr_zero_oe, .local_dram_claim_n, .channel_fault_n, .arb_level, .fault_arb_level,
   .fault_valid, .rom_sel_n, .rom_full_range_en, .row_strobe_n, .col_strobe_n);

// ### tb/lmcc_host_model.sv
// Model of the CPU, bus controller and channel master that issue memory cycles.
`timescale 1ns/1ps
module lmcc_host_model (
   input wire logic clk,
   output logic [3:0] byte_lane_sel_n,
   output logic [31:0] local_addr,
   output logic [1:0] status_n,
   output logic cpu_cycle,
   output logic dma_cycle,
   output logic refresh_cycle,
   output logic master_cycle,
   output logic cpu_mem_io,
   output logic cpu_start_n,
   output logic membus_cmd_n,
   output logic addr_decode_latch_n,
   output logic uz_drv,
   output logic uz_en,
   output logic reg_access,
   output logic reg_write,
   output logic [7:0] mux_drv,
   output logic [7:0] dram_row_col_addr
);
   // ********************************
   // Cycles
   // ********************************
   initial begin
      {byte_lane_sel_n, status_n, cpu_start_n, membus_cmd_n, addr_decode_latch_n} = 9'h1FF;
      {cpu_cycle, dma_cycle, refresh_cycle, master_cycle, cpu_mem_io, uz_drv, uz_en, reg_access, reg_write} = 9'h000;
      local_addr = 32'h0000_0000;
      mux_drv = 8'h00;
      dram_row_col_addr = 8'h00;
   end
   task automatic go(input lmcc_pkg::lmcc_owner_t own, input logic [31:0] a, input logic [3:0] be, input logic mio,
      input logic uz);
      @(posedge clk);
      #1;
      cpu_cycle = own == lmcc_pkg::LMCC_OWN_CPU;
      dma_cycle = own == lmcc_pkg::LMCC_OWN_DMA;
      refresh_cycle = own == lmcc_pkg::LMCC_OWN_RFSH;
      master_cycle = own == lmcc_pkg::LMCC_OWN_MASTER;
      cpu_mem_io = mio;
      local_addr = a;
      dram_row_col_addr = a[9:2];
      byte_lane_sel_n = be;
      uz_en = !cpu_cycle;
      uz_drv = uz;
      status_n = 2'h2;
      repeat (3) @(posedge clk);
      #1;
      cpu_start_n = !cpu_cycle;
      addr_decode_latch_n = cpu_cycle;
      membus_cmd_n = 1'b0;
   endtask : go
   task automatic reg_cyc(input logic wr, input logic [7:0] d);
      @(posedge clk);
      #1;
      reg_access = 1'b1;
      reg_write = wr;
      mux_drv = d;
      repeat (4) @(posedge clk);
      #1;
      membus_cmd_n = 1'b0;
   endtask : reg_cyc
   task automatic stop();
      @(posedge clk);
      #1;
      {cpu_start_n, membus_cmd_n, addr_decode_latch_n, uz_en, reg_access, reg_write} = 6'h38;
      {cpu_cycle, dma_cycle, refresh_cycle, master_cycle} = 4'h0;
      local_addr = ~local_addr;
      byte_lane_sel_n = ~byte_lane_sel_n;
      mux_drv = ~mux_drv;
      status_n = 2'h3;
   endtask : stop
endmodule : lmcc_host_model

// ### tb/lmcc_top_tb.sv
// Self-checking testbench of the local memory cycle control block.
`timescale 1ns/1ps
`include "lmcc_map.svh"
module lmcc_top_tb;
   logic clk, rst_n, cfg_reset, channel_fault_n, data_cmd, arb_phase, cpu_cycle, dma_cycle, refresh_cycle, master_cycle;
   logic cpu_mem_io, cpu_start_n, membus_cmd_n, addr_decode_latch_n, reg_access, reg_write, uz_drv, uz_en;
   logic upper_addr_zero_i, upper_addr_zero_o, upper_addr_zero_oe, local_dram_claim_n, xbus_addr_bit_sixteen_o;
   logic xbus_addr_bit_sixteen_oe, xbus_data_en_n, fault_data_cmd, fault_arb_phase, fault_valid, rom_sel_n;
   logic rom_full_range_en;
   logic [1:0] status_n, fault_status;
   logic [3:0] byte_lane_sel_n, arb_level, fault_arb_level, row_strobe_n;
   logic [7:0] mux_drv, dram_mux_addr_i, dram_mux_addr_o, dram_mux_addr_oe, dram_row_col_addr;
   logic [15:0] col_strobe_n;
   logic [31:0] local_addr, fault_addr;
   int err_count = 0;
   int check_count = 0;
   // ********************************
   // Bench
   // ********************************
   assign upper_addr_zero_i = upper_addr_zero_oe ? upper_addr_zero_o : (uz_en ? uz_drv : 1'b1);
   assign dram_mux_addr_i = (dram_mux_addr_oe & dram_mux_addr_o) | (~dram_mux_addr_oe & mux_drv);
   lmcc_top u_dut (.clk, .rst_n, .cfg_reset, .byte_lane_sel_n, .local_addr, .status_n, .cpu_cycle, .dma_cycle,
      .refresh_cycle, .master_cycle, .cpu_mem_io, .cpu_start_n, .membus_cmd_n, .addr_decode_latch_n, .upper_addr_zero_i,
      .upper_addr_zero_o, .upper_addr_zero_oe, .local_dram_claim_n, .xbus_addr_bit_sixteen_o, .xbus_addr_bit_sixteen_oe,
      .xbus_data_en_n, .dram_mux_addr_i, .dram_mux_addr_o, .dram_mux_addr_oe, .reg_access, .reg_write,
      .dram_row_col_addr, .channel_fault_n, .data_cmd, .arb_phase, .arb_level, .fault_addr, .fault_status,
      .fault_data_cmd, .fault_arb_phase, .fault_arb_level, .fault_valid, .rom_sel_n, .rom_full_range_en, .row_strobe_n,
      .col_strobe_n);
   lmcc_host_model u_host (.clk, .byte_lane_sel_n, .local_addr, .status_n, .cpu_cycle, .dma_cycle, .refresh_cycle,
      .master_cycle, .cpu_mem_io, .cpu_start_n, .membus_cmd_n, .addr_decode_latch_n, .uz_drv, .uz_en, .reg_access,
      .reg_write, .mux_drv, .dram_row_col_addr);
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic stop_test();
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : stop_test
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : wt
   task automatic t_mem(input logic [19:0] top);
      logic [31:0] a [6] = '{32'h0020_0010, 32'h000C_0000, 32'h000D_FFFF, 32'h000E_0000, 32'h000F_FFFF, 32'h0100_0000};
      foreach (a[i]) begin
         u_host.go(lmcc_pkg::LMCC_OWN_CPU, a[i], 4'b1010, 1'b1, 1'b0);
         wt(7);
         check(upper_addr_zero_o, a[i][31:24] == 8'h00);
         check(rom_sel_n, !(a[i][31:20] == 12'h000 && a[i][19:0] >= `LMCC_ROM_BASE && a[i][19:0] <= top));
         u_host.stop();
         wt(4);
      end
      $display("test memory map done");
   endtask : t_mem
   task automatic t_dram();
      u_host.go(lmcc_pkg::LMCC_OWN_CPU, 32'h0020_0010, 4'b1010, 1'b1, 1'b0);
      wt(7);
      check(local_dram_claim_n, 1'b0);
      check(row_strobe_n, 4'b1011);
      check(col_strobe_n, 16'hFAFF);
      cfg_reset = 1'b1;
      wt(4);
      check(col_strobe_n, `LMCC_CAS_IDLE);
      cfg_reset = 1'b0;
      u_host.stop();
      wt(4);
      check(row_strobe_n, `LMCC_RAS_IDLE);
      $display("test dram done");
   endtask : t_dram
   task automatic t_reg();
      u_host.reg_cyc(1'b1, 8'h00);
      wt(3);
      check(xbus_data_en_n, 1'b0);
      u_host.stop();
      wt(4);
      check(rom_full_range_en, 1'b0);
      check(xbus_data_en_n, 1'b1);
      t_mem(`LMCC_ROM_TOP_PART);
      u_host.reg_cyc(1'b0, 8'hFF);
      wt(4);
      check(dram_mux_addr_o[0], 1'b0);
      check(dram_mux_addr_oe, 8'hFF);
      u_host.stop();
      cfg_reset = 1'b1;
      wt(4);
      check(rom_full_range_en, 1'b1);
      cfg_reset = 1'b0;
      $display("test registers done");
   endtask : t_reg
   task automatic t_io();
      u_host.go(lmcc_pkg::LMCC_OWN_CPU, 32'h0001_0000, 4'h0, 1'b0, 1'b0);
      wt(6);
      check({xbus_addr_bit_sixteen_oe, xbus_addr_bit_sixteen_o}, 2'h3);
      u_host.stop();
      wt(4);
      check(xbus_addr_bit_sixteen_oe, 1'b0);
      $display("test io done");
   endtask : t_io
   task automatic t_foreign(input lmcc_pkg::lmcc_owner_t own, input logic uz, input logic [4:0] exp);
      u_host.go(own, 32'h0010_0000, 4'h0, 1'b1, uz);
      wt(8);
      check(upper_addr_zero_oe, 1'b0);
      check({local_dram_claim_n, row_strobe_n}, exp);
      u_host.stop();
      wt(4);
      $display("test foreign cycle done");
   endtask : t_foreign
   task automatic t_fault(input logic [3:0] lvl, input logic ph, input logic dc);
      channel_fault_n = 1'b1;
      wt(2);
      {arb_level, arb_phase, data_cmd, channel_fault_n} = {lvl, ph, dc, 1'b0};
      wt(6);
      check(fault_addr, 32'h0010_0000);
      check({fault_valid, fault_status}, 3'h6);
      check(fault_data_cmd, dc);
      check(fault_arb_phase, ph);
      check(fault_arb_level, lvl);
      $display("test fault done");
   endtask : t_fault
   initial begin
      #1_000_000;
      err_count++;
      stop_test();
   end
   initial begin
      {rst_n, cfg_reset, channel_fault_n, data_cmd, arb_phase, arb_level} = 9'h040;
      repeat (5) @(posedge clk);
      #1;
      check(row_strobe_n, `LMCC_RAS_IDLE);
      rst_n = 1'b1;
      wt(3);
      check(rom_full_range_en, 1'b1);
      t_mem(`LMCC_ROM_TOP_FULL);
      t_dram();
      t_reg();
      t_io();
      t_foreign(lmcc_pkg::LMCC_OWN_MASTER, 1'b0, 5'h1F);
      t_foreign(lmcc_pkg::LMCC_OWN_MASTER, 1'b1, 5'h0D);
      t_foreign(lmcc_pkg::LMCC_OWN_RFSH, 1'b1, 5'h10);
      t_foreign(lmcc_pkg::LMCC_OWN_DMA, 1'b1, 5'h0D);
      t_fault(4'hA, 1'b1, 1'b0);
      t_fault(4'h5, 1'b0, 1'b1);
      stop_test();
   end
endmodule : lmcc_top_tb
